// file: hw/xlate_cfg.svh
`ifndef XLATE_CFG_SVH
`define XLATE_CFG_SVH
`define RESET_FETCH_ADDR 32'hFFFF_FFF0
`define DATA_SEG_RESET_BASE 32'h0000_0000
`define PAGE_OFS_BITS 12
`define PDE_IDX_MSB 31
`define PDE_IDX_LSB 22
`define PTE_IDX_MSB 21
`define PTE_IDX_LSB 12
`define SEL_IDX_MSB 15
`define SEL_IDX_LSB 3
`define SEL_TABLE_BIT 2
`define DESC_BYTES_SHIFT 3
`define ENTRY_PRESENT_BIT 0
`define ENTRY_WRITE_BIT 1
`define ENTRY_USER_BIT 2
`define NUM_SEGS 6
`define SEG_CODE 3'h0
`define SEG_STACK 3'h1
`define SEG_DATA 3'h2
`define PRIV_USER 2'h3
`endif

// file: hw/xlate_pkg.sv
package xlate_pkg;
  typedef enum logic [2:0] {
    FAULT_NONE,
    FAULT_LIMIT,
    FAULT_TYPE,
    FAULT_NULL,
    FAULT_PAGE_ABSENT,
    FAULT_PAGE_PRIV
  } fault_t;

  typedef struct packed {
    logic valid;
    logic [31:0] base;
    logic [31:0] limit;
    logic isCode;
    logic writable;
    logic readable;
    logic [1:0] privLevel;
  } seg_desc_t;
endpackage

// file: hw/desc_fetch_if.sv
`timescale 1ns/1ns
`default_nettype none
// carries one word read request/answer to the page table memory
interface desc_fetch_if;
  logic req;
  logic [31:0] addr;
  logic ack;
  logic [31:0] data;
  modport master (output req, output addr, input ack, input data);
  modport slave (input req, input addr, output ack, output data);
endinterface
`default_nettype wire

// file: hw/table_walker.sv
`timescale 1ns/1ns
`default_nettype none
`include "xlate_cfg.svh"
// two-level walk: directory entry, then table entry
module table_walker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [31:0] dirBase,
  input wire logic [31:0] linAddr,
  input wire logic isWrite,
  input wire logic isUser,
  output logic done,
  output logic [31:0] physAddr,
  output logic absent,
  output logic privFault,
  desc_fetch_if.master mem
);
  import xlate_pkg::*;

  typedef enum logic [1:0] {W_IDLE, W_DIR, W_TAB, W_DONE} wstate_t;
  typedef struct packed {
    wstate_t st;
    logic [31:0] addr;
    logic [31:0] phys;
    logic absent;
    logic priv;
  } walk_t;
  walk_t s_r, s_nxt;

  function automatic logic entryDenied(input logic [31:0] e, input logic wr, input logic usr);
    entryDenied = (usr && !e[`ENTRY_USER_BIT]) || (usr && wr && !e[`ENTRY_WRITE_BIT]);
  endfunction

  always_comb begin
    s_nxt = s_r;
    unique case (s_r.st)
      W_IDLE: begin
        if (start) begin
          s_nxt.st = W_DIR;
          s_nxt.absent = 1'b0;
          s_nxt.priv = 1'b0;
          s_nxt.addr = {dirBase[31:`PAGE_OFS_BITS],
                        linAddr[`PDE_IDX_MSB:`PDE_IDX_LSB], 2'b00};
        end
      end
      W_DIR: begin
        if (mem.ack) begin
          if (!mem.data[`ENTRY_PRESENT_BIT]) begin
            s_nxt.absent = 1'b1;
            s_nxt.st = W_DONE;
          end else begin
            s_nxt.priv = entryDenied(mem.data, isWrite, isUser);
            s_nxt.addr = {mem.data[31:`PAGE_OFS_BITS],
                          linAddr[`PTE_IDX_MSB:`PTE_IDX_LSB], 2'b00};
            s_nxt.st = W_TAB;
          end
        end
      end
      W_TAB: begin
        if (mem.ack) begin
          s_nxt.absent = !mem.data[`ENTRY_PRESENT_BIT];
          s_nxt.priv = s_r.priv || entryDenied(mem.data, isWrite, isUser);
          // low offset passes untranslated
          s_nxt.phys = {mem.data[31:`PAGE_OFS_BITS],
                        linAddr[`PAGE_OFS_BITS-1:0]};
          s_nxt.st = W_DONE;
        end
      end
      W_DONE: s_nxt.st = W_IDLE;
    endcase
    if (!rst_n) begin
      s_nxt = '0;
      s_nxt.st = W_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    s_r <= s_nxt;
  end

  assign mem.req = (s_r.st == W_DIR) || (s_r.st == W_TAB);
  assign mem.addr = s_r.addr;
  assign done = (s_r.st == W_DONE);
  assign physAddr = s_r.phys;
  assign absent = s_r.absent;
  assign privFault = s_r.priv;
endmodule
`default_nettype wire

// file: hw/seg_check.sv
`timescale 1ns/1ns
`default_nettype none
`include "xlate_cfg.svh"
// pure segment stage: base add plus limit, type and null checks
module seg_check (
  input wire xlate_pkg::seg_desc_t desc,
  input wire logic [31:0] offset,
  input wire logic isWrite,
  output logic [31:0] linAddr,
  output xlate_pkg::fault_t fault
);
  import xlate_pkg::*;

  always_comb begin
    linAddr = desc.base + offset;
    fault = FAULT_NONE;
    // an unloaded (null) register faults only when used
    if (!desc.valid) begin
      fault = FAULT_NULL;
    end else if (offset > desc.limit) begin
      // a limit of all ones can never trip this compare
      fault = FAULT_LIMIT;
    end else if (isWrite && (desc.isCode || !desc.writable)) begin
      fault = FAULT_TYPE;
    end else if (!isWrite && !desc.isCode && !desc.readable) begin
      fault = FAULT_TYPE;
    end
  end
endmodule
`default_nettype wire

// file: hw/segment_page_address_translation.sv
`timescale 1ns/1ns
`default_nettype none
`include "xlate_cfg.svh"
module segment_page_address_translation (
  input wire logic core_clk,
  input wire logic rst_n,
  // segment register load
  input wire logic segLoad,
  input wire logic [2:0] segLoadIdx,
  input wire logic [15:0] segLoadSel,
  input wire xlate_pkg::seg_desc_t segLoadDesc,
  input wire logic [31:0] globalTableBase,
  input wire logic [31:0] localTableBase,
  output logic [31:0] descAddr,
  output logic loadDone,
  // access request
  input wire logic accReq,
  output logic accReady,
  input wire logic [2:0] accSeg,
  input wire logic [31:0] accOffset,
  input wire logic accWrite,
  input wire logic [31:0] accWdata,
  input wire logic pagingEnable,
  input wire logic [31:0] pageDirBase,
  output logic accDone,
  output logic [31:0] accRdata,
  output logic general_protection_fault,
  output logic pageFault,
  output xlate_pkg::fault_t faultCause,
  output logic [31:0] faultAddr,
  // page table memory port
  output logic ptReq,
  output logic [31:0] ptAddr,
  input wire logic ptAck,
  input wire logic [31:0] ptData,
  // physical bus
  output logic busReq,
  output logic busWrite,
  output logic [31:0] busAddr,
  output logic [31:0] busWdata,
  input wire logic busAck,
  input wire logic [31:0] busRdata,
  output logic [31:0] fetchAddr
);
  import xlate_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {S_IDLE, S_WALK, S_BUS, S_DONE} state_t;

  typedef struct packed {
    state_t st;
    seg_desc_t [`NUM_SEGS-1:0] seg;
    logic [31:0] lin;
    logic [31:0] phys;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic gp;
    logic pf;
    fault_t cause;
    logic [31:0] faddr;
    logic [31:0] daddr;
    logic ldone;
    logic walkStart;
    logic isUser;
    logic [31:0] fetch;
  } core_t;
  core_t s_r, s_nxt;

  function automatic logic isNullSel(input logic [15:0] sel);
    isNullSel = (sel[`SEL_IDX_MSB:`SEL_TABLE_BIT] == 14'h0000);
  endfunction

  // ****************************************
  // segment register load
  // ****************************************
  // code and stack may never hold a null selector
  function automatic logic needsSelector(input logic [2:0] idx);
    needsSelector = (idx == `SEG_CODE) || (idx == `SEG_STACK);
  endfunction

  // index scaled by the descriptor size, added to the chosen table
  function automatic logic [31:0] descLocate(
    input logic [15:0] sel,
    input logic [31:0] gBase,
    input logic [31:0] lBase
  );
    logic [31:0] tBase;
    logic [31:0] scaled;
    tBase = sel[`SEL_TABLE_BIT] ? lBase : gBase;
    scaled = {16'h0000, 3'h0, sel[`SEL_IDX_MSB:`SEL_IDX_LSB]} << `DESC_BYTES_SHIFT;
    descLocate = tBase + scaled;
  endfunction

  // ****************************************
  // segment stage
  // ****************************************
  logic [31:0] linAddr;
  fault_t segFault;

  seg_check u_seg (
    .desc(s_r.seg[accSeg]),
    .offset(accOffset),
    .isWrite(accWrite),
    .linAddr(linAddr),
    .fault(segFault)
  );

  // ****************************************
  // page walker
  // ****************************************
  desc_fetch_if ptIf ();
  logic walkDone;
  logic [31:0] walkPhys;
  logic walkAbsent;
  logic walkPriv;

  table_walker u_walk (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(s_r.walkStart),
    .dirBase(pageDirBase),
    .linAddr(s_r.lin),
    .isWrite(s_r.wr),
    .isUser(s_r.isUser),
    .done(walkDone),
    .physAddr(walkPhys),
    .absent(walkAbsent),
    .privFault(walkPriv),
    .mem(ptIf.master)
  );

  assign ptReq = ptIf.req;
  assign ptAddr = ptIf.addr;
  assign ptIf.ack = ptAck;
  assign ptIf.data = ptData;

  // ****************************************
  // next state
  // ****************************************
  logic nullLoadFault;
  logic loadAccepted;

  // a refused load keeps the old descriptor in place
  always_comb begin
    nullLoadFault = segLoad && isNullSel(segLoadSel) && needsSelector(segLoadIdx);
    loadAccepted = segLoad && !nullLoadFault;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.walkStart = 1'b0;
    s_nxt.ldone = 1'b0;

    if (segLoad) begin
      s_nxt.daddr = descLocate(segLoadSel, globalTableBase, localTableBase);
      s_nxt.ldone = 1'b1;
    end
    if (loadAccepted) begin
      s_nxt.seg[segLoadIdx] = segLoadDesc;
      s_nxt.seg[segLoadIdx].valid = !isNullSel(segLoadSel);
    end

    unique case (s_r.st)
      S_IDLE: begin
        if (accReq) begin
          s_nxt.gp = 1'b0;
          s_nxt.pf = 1'b0;
          s_nxt.cause = FAULT_NONE;
          s_nxt.lin = linAddr;
          s_nxt.wr = accWrite;
          s_nxt.wdata = accWdata;
          s_nxt.isUser = (s_r.seg[accSeg].privLevel == `PRIV_USER);
          // every access goes through the segment check first
          if (segFault != FAULT_NONE) begin
            s_nxt.gp = 1'b1;
            s_nxt.cause = segFault;
            s_nxt.faddr = accOffset;
            s_nxt.st = S_DONE;
          end else if (pagingEnable) begin
            s_nxt.walkStart = 1'b1;
            s_nxt.st = S_WALK;
          end else begin
            s_nxt.phys = linAddr;
            s_nxt.st = S_BUS;
          end
        end
      end
      S_WALK: begin
        if (walkDone) begin
          if (walkAbsent || walkPriv) begin
            // abort before any bus cycle is issued
            s_nxt.pf = 1'b1;
            s_nxt.cause = walkAbsent ? FAULT_PAGE_ABSENT : FAULT_PAGE_PRIV;
            s_nxt.faddr = s_r.lin;
            s_nxt.st = S_DONE;
          end else begin
            s_nxt.phys = walkPhys;
            s_nxt.st = S_BUS;
          end
        end
      end
      S_BUS: begin
        if (busAck) begin
          s_nxt.rdata = busRdata;
          s_nxt.st = S_DONE;
        end
      end
      S_DONE: s_nxt.st = S_IDLE;
      default: s_nxt.st = S_IDLE;
    endcase

    // set wins over the clear of a newly taken access
    if (nullLoadFault) begin
      s_nxt.gp = 1'b1;
      s_nxt.cause = FAULT_NULL;
    end

    if (!rst_n) begin
      s_nxt = '0;
      s_nxt.st = S_IDLE;
      s_nxt.fetch = `RESET_FETCH_ADDR;
      s_nxt.seg[`SEG_DATA].base = `DATA_SEG_RESET_BASE;
    end
  end

  always_ff @(posedge core_clk) begin
    s_r <= s_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign accReady = (s_r.st == S_IDLE);
  assign accDone = (s_r.st == S_DONE);
  assign accRdata = s_r.rdata;
  assign general_protection_fault = s_r.gp;
  assign pageFault = s_r.pf;
  assign faultCause = s_r.cause;
  assign faultAddr = s_r.faddr;
  assign descAddr = s_r.daddr;
  assign loadDone = s_r.ldone;
  assign busReq = (s_r.st == S_BUS);
  assign busWrite = (s_r.st == S_BUS) && s_r.wr;
  assign busAddr = s_r.phys;
  assign busWdata = s_r.wdata;
  assign fetchAddr = s_r.fetch;
endmodule
`default_nettype wire

// file: tb/xlate_checker.sv
`timescale 1ns/1ns
`default_nettype none
module xlate_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic segLoad,
  input wire logic [2:0] segLoadIdx,
  input wire logic [15:0] segLoadSel,
  input wire xlate_pkg::seg_desc_t segLoadDesc,
  input wire logic [31:0] globalTableBase,
  input wire logic [31:0] localTableBase,
  input wire logic [31:0] descAddr,
  input wire logic loadDone,
  input wire logic accReq,
  input wire logic accReady,
  input wire logic [2:0] accSeg,
  input wire logic [31:0] accOffset,
  input wire logic pagingEnable,
  input wire logic [31:0] pageDirBase,
  input wire logic accDone,
  input wire logic general_protection_fault,
  input wire logic pageFault,
  input wire xlate_pkg::fault_t faultCause,
  input wire logic ptReq,
  input wire logic [31:0] ptAddr,
  input wire logic busReq,
  input wire logic [31:0] busAddr,
  input wire logic [31:0] fetchAddr
);
  import xlate_pkg::*;
  // shadow of segment bases, so the expected linear address is our own
  logic [31:0] segBase_r [8];
  logic [31:0] lin_r;
  logic [15:0] sel_r;
  logic [31:0] gBase_r;
  logic [31:0] lBase_r;
  always_ff @(posedge core_clk) begin
    // a null load into code or stack is refused and leaves the base alone
    if (segLoad && !(segLoadIdx < 3'h2 && segLoadSel[15:2] == 14'h0))
      segBase_r[segLoadIdx] <= segLoadDesc.base;
    if (accReq && accReady) lin_r <= segBase_r[accSeg] + accOffset;
    sel_r <= segLoadSel;
    gBase_r <= globalTableBase;
    lBase_r <= localTableBase;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // properties
  // ****************
  sequence s_take;
    accReq && accReady;
  endsequence
  sequence s_walk;
    s_take ##0 pagingEnable ##2 ptReq;
  endsequence
  property p_fetch;
    $rose(rst_n) |-> fetchAddr == 32'hFFFF_FFF0;
  endproperty
  property p_descAddr;
    loadDone |-> descAddr == (sel_r[2] ? lBase_r : gBase_r) + {16'h0000, sel_r[15:3], 3'b000};
  endproperty
  property p_nullLoad;
    segLoad && segLoadIdx < 3'h2 && segLoadSel[15:2] == 14'h0 |=> general_protection_fault;
  endproperty
  property p_noBus;
    general_protection_fault || pageFault |-> !busReq;
  endproperty
  property p_segCause;
    accDone && general_protection_fault |->
      !pageFault && faultCause inside {FAULT_LIMIT, FAULT_TYPE, FAULT_NULL};
  endproperty
  property p_pageCause;
    accDone && pageFault |->
      !general_protection_fault && faultCause inside {FAULT_PAGE_ABSENT, FAULT_PAGE_PRIV};
  endproperty
  property p_direct;
    busReq && !pagingEnable |-> busAddr == lin_r;
  endproperty
  property p_pageOfs;
    busReq && pagingEnable |-> busAddr[11:0] == lin_r[11:0];
  endproperty
  property p_dirAddr;
    s_walk |-> ptAddr == {pageDirBase[31:12], lin_r[31:22], 2'b00};
  endproperty
  property p_done;
    s_take |-> ##[1:40] accDone;
  endproperty
  a_fetch: assert property (p_fetch) else $error("bad fetch address");
  a_descAddr: assert property (p_descAddr) else $error("bad descriptor address");
  a_nullLoad: assert property (p_nullLoad) else $error("null load not faulted");
  a_noBus: assert property (p_noBus) else $error("bus used on fault");
  a_segCause: assert property (p_segCause) else $error("bad segment cause");
  a_pageCause: assert property (p_pageCause) else $error("bad page cause");
  a_direct: assert property (p_direct) else $error("bad direct address");
  a_pageOfs: assert property (p_pageOfs) else $error("page offset changed");
  a_dirAddr: assert property (p_dirAddr) else $error("bad directory address");
  a_done: assert property (p_done) else $error("access never done");
endmodule
bind segment_page_address_translation xlate_checker chk (.*);
`default_nettype wire

// file: tb/core_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// table words carry their own address folded, so walks are predictable
module core_mem_model (
  input wire logic core_clk,
  input wire logic [1:0] memDelay,
  input wire logic [2:0] ptFlags,
  input wire logic ptReq,
  input wire logic [31:0] ptAddr,
  output logic ptAck,
  output logic [31:0] ptData,
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busWdata,
  output logic busAck,
  output logic [31:0] busRdata,
  output var logic [7:0] wrCount,
  output var logic [31:0] lastWdata
);
  logic [1:0] wait_r = 2'h0;
  logic [31:0] noise_r = 32'h0000_0000;
  initial wrCount = 8'h00;
  assign ptAck = ptReq && wait_r == memDelay;
  assign busAck = busReq && wait_r == memDelay;
  // released lines move every cycle, never the last answer
  assign ptData = ptAck ? {ptAddr[31:12] ^ 20'hA_5A5A, 9'h000, ptFlags} : noise_r;
  assign busRdata = busAck ? ~busAddr : noise_r;
  always @(posedge core_clk) begin
    noise_r <= noise_r + 32'h0101_0101;
    wait_r <= (ptAck || busAck || !(ptReq || busReq)) ? 2'h0 : wait_r + 2'h1;
    if (busAck && busWrite) begin
      wrCount <= wrCount + 8'h01;
      lastWdata <= busWdata;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import xlate_pkg::*;
  logic core_clk = 0, rst_n = 0, segLoad = 0, accReq = 0, accWrite = 0, pagingEnable = 0;
  logic loadDone, accReady, accDone, general_protection_fault, pageFault;
  logic ptReq, ptAck, busReq, busWrite, busAck;
  logic [1:0] memDelay = 2'h0;
  logic [2:0] segLoadIdx = 3'h0, accSeg = 3'h0, ptFlags = 3'h0;
  logic [7:0] wrCount;
  logic [31:0] lastWdata;
  logic [15:0] segLoadSel = 16'h0000;
  seg_desc_t segLoadDesc = '0;
  logic [31:0] globalTableBase = 32'h0001_0000, localTableBase = 32'h0002_0000;
  logic [31:0] accOffset = 0, accWdata = 0, pageDirBase = 32'h0040_0000;
  logic [31:0] descAddr, accRdata, faultAddr, ptAddr, ptData, busAddr, busWdata;
  logic [31:0] busRdata, fetchAddr;
  fault_t faultCause;
  int errors = 0, samples_checked = 0, cycles = 0;
  segment_page_address_translation dut (.*);
  core_mem_model mem (.*);
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      summarize;
    end
  end
  // ****************
  // helpers
  // ****************
  task automatic summarize;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic seg_desc_t mk(logic [31:0] b, logic [31:0] l, logic c, logic [1:0] p);
    return '{1'b1, b, l, c, !c, 1'b1, p};
  endfunction
  task automatic load(logic [2:0] i, logic [15:0] s, seg_desc_t d);
    segLoad = 1;
    segLoadIdx = i;
    segLoadSel = s;
    segLoadDesc = d;
    @(negedge core_clk);
    segLoad = 0;
    @(negedge core_clk);
  endtask
  // wait up to 40 cycles for accReady, then raise the request so the next edge takes it
  task automatic acc(logic [2:0] s, logic [31:0] o, logic w);
    int n;
    n = 0;
    while (accReady !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    accReq = 1;
    accSeg = s;
    accOffset = o;
    accWrite = w;
    accWdata = ~o;
    @(negedge core_clk);
    accReq = 0;
    n = 0;
    while (accDone !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk(accDone, 1);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_seg;
    chk(fetchAddr, 32'hFFFF_FFF0);
    load(3'h4, 16'h002C, mk(32'h1000_0000, 32'h0000_00FF, 0, 0));
    chk(descAddr, 32'h0002_0028);
    load(3'h2, 16'h0030, mk(32'h0, 32'hFFFF_FFFF, 0, 0));
    chk(descAddr, 32'h0001_0030);
    acc(3'h2, 32'hFFFF_FFFC, 1'b0);
    chk(general_protection_fault, 0);
    chk(accRdata, 32'h0000_0003);
    acc(3'h4, 32'h0000_00FF, 1'b0);
    chk(accRdata, 32'hEFFF_FF00);
    acc(3'h4, 32'h0000_0080, 1'b1);
    chk(lastWdata, 32'hFFFF_FF7F);
    acc(3'h4, 32'h0000_0100, 1'b1);
    chk(faultCause, FAULT_LIMIT);
    chk(faultAddr, 32'h0000_0100);
    chk(wrCount, 1);
  endtask
  task automatic t_code_null;
    load(3'h0, 16'h0008, mk(32'h0, 32'hFFFF_FFFF, 1, 0));
    acc(3'h0, 32'h0000_0020, 1'b1);
    chk(faultCause, FAULT_TYPE);
    acc(3'h0, 32'h0000_0020, 1'b0);
    chk(general_protection_fault, 0);
    load(3'h1, 16'h0003, '0);
    chk(general_protection_fault, 1);
    load(3'h3, 16'h0000, '0);
    acc(3'h3, 32'h0, 1'b0);
    chk(faultCause, FAULT_NULL);
  endtask
  task automatic t_page;
    pagingEnable = 1;
    memDelay = 2'h3;
    ptFlags = 3'h7;
    acc(3'h2, 32'h0123_4567, 1'b0);
    chk(accRdata, ~{pageDirBase[31:12], 12'h567});
    ptFlags = 3'h0;
    acc(3'h2, 32'h0123_4567, 1'b1);
    chk(faultCause, FAULT_PAGE_ABSENT);
    chk(pageFault, 1);
    chk(faultAddr, 32'h0123_4567);
    ptFlags = 3'h3;
    load(3'h5, 16'h0013, mk(32'h0, 32'hFFFF_FFFF, 0, 3));
    acc(3'h5, 32'h0000_0040, 1'b0);
    chk(faultCause, FAULT_PAGE_PRIV);
    pagingEnable = 0;
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    rst_n = 1;
    @(negedge core_clk);
    t_seg;
    t_code_null;
    t_page;
    summarize;
  end
endmodule
`default_nettype wire
